// ==== timer16_pkg.sv ====
// Constants shared by the 16-bit timer block: register map, field positions,
// reset values, timing figures.
// Assumes an 8-bit register address space and a single system clock.
package timer16_pkg;

  // Clock and oscillator figures
  localparam int SYS_CLK_HZ     = 25000000;
  localparam int OSC_MAX_HZ     = 200000;
  localparam int OSC_MIN_CYCLES = (SYS_CLK_HZ + OSC_MAX_HZ - 1) / OSC_MAX_HZ;

  // Register offsets
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL   = 8'h0b;
  localparam logic [7:0] ADDR_PERIPHERAL_FLAGS    = 8'h0c;
  localparam logic [7:0] ADDR_COUNT_LOW_BYTE      = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HIGH_BYTE     = 8'h0f;
  localparam logic [7:0] ADDR_TIMER_CONTROL       = 8'h10;
  localparam logic [7:0] ADDR_PERIPHERAL_ENABLES  = 8'h8c;

  // Timer control fields
  localparam int BIT_RUN_ENABLE    = 0;
  localparam int BIT_CLOCK_SOURCE  = 1;
  localparam int BIT_SYNC_DISABLE  = 2;
  localparam int BIT_OSC_ENABLE    = 3;
  localparam int POS_PRESCALE_LO   = 4;
  localparam int POS_PRESCALE_HI   = 5;
  localparam logic [7:0] TIMER_CONTROL_MASK = 8'h3f;

  // Interrupt fields
  localparam int BIT_OVERFLOW_FLAG     = 0;
  localparam int BIT_OVERFLOW_IRQ_EN   = 0;
  localparam int BIT_GLOBAL_IRQ_EN     = 7;
  localparam int BIT_PERIPHERAL_IRQ_EN = 6;
  localparam logic [7:0] PERIPHERAL_MASK = 8'hcf;

  // Reset values
  localparam logic [7:0] TIMER_CONTROL_RESET      = 8'h00;
  localparam logic [7:0] PERIPHERAL_FLAGS_RESET   = 8'h00;
  localparam logic [7:0] PERIPHERAL_ENABLES_RESET = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] READ_IDLE                = 8'h00;

  // Compare unit mode that drives the counter clear
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;

  // Counter limits
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [2:0]  PRESC_ZERO = 3'h0;

endpackage

// ==== timer16.sv ====
// 16-bit timer/counter with prescaler, dedicated crystal oscillator pins,
// compare-unit clear and overflow interrupt, on a plain register port.
// Assumes the compare unit and sleep control sit on clk_sys; pins are async.
`timescale 1ns/1ps

// How it works
// - Oscillator enable bit starts crystal amplifier
// - Oscillator clock usable as count source
// - Oscillator not gated by sleep
// - Special event trigger clears counter
// - Trigger clear never sets overflow flag
// - Counter write beats simultaneous trigger
// - Compare pair acts as counter period
// - Counter bytes untouched by any reset
// - Control zeroed only by power-on reset
// - Counter byte write clears prescaler
// - Count read/written as two bytes
// - Prescale field divides by 1,2,4,8
// - Clock source selects internal or external
// - Run bit enables counting
// - Async mode counts in sleep; sync stops
module timer16
  import timer16_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        soft_reset,
  input  wire logic        sleep_mode,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        crystal_input_pin,
  output logic             crystal_output_pin_o,
  output logic             crystal_output_pin_oe,
  input  wire logic        external_count_clock_pin,
  input  wire logic [3:0]  compare_unit_mode_field,
  input  wire logic        special_event_trigger,
  output logic      [15:0] count_value,
  output logic             irq
);

  // Registers
  logic [7:0]  timer_control_q;
  logic [7:0]  peripheral_flags_q;
  logic [7:0]  peripheral_enables_q;
  logic [7:0]  interrupt_control_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [2:0]  presc_q;
  logic [2:0]  presc_d;
  logic [7:0]  rdata_q;
  logic        xtal_s1_q;
  logic        xtal_s2_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        src_prev_q;
  logic        xtal_out_q;
  logic [1:0]  loaded_q;

  // Decode of the register port
  wire wr_low   = reg_write && (reg_addr == ADDR_COUNT_LOW_BYTE);
  wire wr_high  = reg_write && (reg_addr == ADDR_COUNT_HIGH_BYTE);
  wire wr_count = wr_low || wr_high;
  wire wr_tctl  = reg_write && (reg_addr == ADDR_TIMER_CONTROL);
  wire wr_flags = reg_write && (reg_addr == ADDR_PERIPHERAL_FLAGS);
  wire wr_enab  = reg_write && (reg_addr == ADDR_PERIPHERAL_ENABLES);
  wire wr_intc  = reg_write && (reg_addr == ADDR_INTERRUPT_CONTROL);

  // Control fields
  wire       run_enable_bit      = timer_control_q[BIT_RUN_ENABLE];
  wire       clock_source_select = timer_control_q[BIT_CLOCK_SOURCE];
  wire       sync_disable_bit    = timer_control_q[BIT_SYNC_DISABLE];
  wire       osc_enable_bit      = timer_control_q[BIT_OSC_ENABLE];
  wire [1:0] prescale_select     = timer_control_q[POS_PRESCALE_HI:POS_PRESCALE_LO];

  // Prescaler terminal count: 0,1,3,7 for 1:1,1:2,1:4,1:8
  wire [2:0] presc_max = 3'(( 4'h1 << prescale_select) - 4'h1);

  // External source: crystal input when oscillator is on, else the clock pin
  wire src_level = osc_enable_bit ? xtal_s2_q : ext_s2_q;
  wire ext_edge  = src_level && !src_prev_q;
  wire presc_in  = clock_source_select ? ext_edge : 1'b1;
  wire presc_tick = run_enable_bit && presc_in && (presc_q == presc_max);

  // Sleep stops synced external counting and the internal clock; async mode runs on
  wire async_mode  = clock_source_select && sync_disable_bit;
  wire count_allow = !sleep_mode || async_mode;
  wire count_inc   = presc_tick && count_allow && run_enable_bit;

  // Compare unit clear; a counter write takes precedence
  wire trig_clear = special_event_trigger &&
                    (compare_unit_mode_field == MODE_SPECIAL_EVENT);
  wire ovf_wrap   = count_inc && (count_q == COUNT_MAX) && !wr_count && !trig_clear;

  // Overflow flag set beats a software clear in the same cycle
  wire flag_set   = ovf_wrap;
  wire flag_clr   = wr_flags && reg_wdata[BIT_OVERFLOW_FLAG];

  // Interrupt output: flag gated by enable and the two global enables
  assign irq = peripheral_flags_q[BIT_OVERFLOW_FLAG] &&
               peripheral_enables_q[BIT_OVERFLOW_IRQ_EN] &&
               interrupt_control_q[BIT_GLOBAL_IRQ_EN] &&
               interrupt_control_q[BIT_PERIPHERAL_IRQ_EN];

  assign count_value           = count_q;
  assign reg_rdata             = rdata_q;
  assign crystal_output_pin_o  = xtal_out_q;
  assign crystal_output_pin_oe = osc_enable_bit;

  // Next count: write, then trigger clear, then increment
  always_comb begin
    count_d = count_q;
    if (wr_low) begin
      count_d[7:0] = reg_wdata;
    end else if (wr_high) begin
      count_d[15:8] = reg_wdata;
    end else if (trig_clear) begin
      // Compare match clears here, so the compare pair is the period
      count_d = COUNT_ZERO;
    end else if (count_inc) begin
      count_d = 16'(count_q + 16'h0001);
    end
  end

  // Next prescaler count; counts on while asleep in sync mode
  always_comb begin
    presc_d = presc_q;
    if (wr_count || soft_reset) begin
      presc_d = PRESC_ZERO;
    end else if (run_enable_bit && presc_in) begin
      presc_d = (presc_q == presc_max) ? PRESC_ZERO : 3'(presc_q + 3'h1);
    end
  end

  // Counter bytes carry no reset at all; content after power-up is unknown
  always_ff @(posedge clk_sys) begin
    count_q <= count_d;
  end

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
    end else begin
      xtal_s1_q <= crystal_input_pin;
      xtal_s2_q <= xtal_s1_q;
      ext_s1_q  <= external_count_clock_pin;
      ext_s2_q  <= ext_s1_q;
    end
  end

  // Edge history and crystal amplifier; sleep does not gate the amplifier
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_q <= 1'b0;
      xtal_out_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
      xtal_out_q <= osc_enable_bit && !xtal_s2_q;
    end
  end

  // Prescaler state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= PRESC_ZERO;
    end else begin
      presc_q <= presc_d;
    end
  end

  // Timer control: only power-on reset clears it, soft reset leaves it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_control_q <= TIMER_CONTROL_RESET;
    end else if (wr_tctl) begin
      timer_control_q <= reg_wdata & TIMER_CONTROL_MASK;
    end
  end

  // Flags and enables are cleared by every reset; soft reset keeps interrupt control bit 0
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      peripheral_flags_q   <= PERIPHERAL_FLAGS_RESET;
      peripheral_enables_q <= PERIPHERAL_ENABLES_RESET;
      interrupt_control_q  <= INTERRUPT_CONTROL_RESET;
    end else if (soft_reset) begin
      peripheral_flags_q   <= PERIPHERAL_FLAGS_RESET;
      peripheral_enables_q <= PERIPHERAL_ENABLES_RESET;
      interrupt_control_q  <= {INTERRUPT_CONTROL_RESET[7:1], interrupt_control_q[0]};
    end else begin
      if (flag_set || (flag_clr == 1'b0)) begin
        peripheral_flags_q[BIT_OVERFLOW_FLAG] <=
          peripheral_flags_q[BIT_OVERFLOW_FLAG] || flag_set;
      end else begin
        peripheral_flags_q[BIT_OVERFLOW_FLAG] <= 1'b0;
      end
      if (wr_enab) begin
        peripheral_enables_q <= reg_wdata & PERIPHERAL_MASK;
      end
      if (wr_intc) begin
        interrupt_control_q <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  wire [7:0] rd_mux =
    (reg_addr == ADDR_COUNT_LOW_BYTE)     ? count_q[7:0]  :
    (reg_addr == ADDR_COUNT_HIGH_BYTE)    ? count_q[15:8] :
    (reg_addr == ADDR_TIMER_CONTROL)      ? timer_control_q :
    (reg_addr == ADDR_PERIPHERAL_FLAGS)   ? peripheral_flags_q :
    (reg_addr == ADDR_PERIPHERAL_ENABLES) ? peripheral_enables_q :
    (reg_addr == ADDR_INTERRUPT_CONTROL)  ? interrupt_control_q : READ_IDLE;

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= READ_IDLE;
    end else if (reg_read) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= READ_IDLE;
    end
  end

  // Counter bytes loaded since power-on; the counter has no reset, so
  // checks on its value wait until both bytes are known
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 2'h0;
    end else begin
      loaded_q <= loaded_q | {wr_high || trig_clear, wr_low || trig_clear};
    end
  end

  wire count_known = &loaded_q;

  // Checks

  property p_osc_pin_enable;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_tctl && reg_wdata[BIT_OSC_ENABLE] |=> crystal_output_pin_oe;
  endproperty
  a_osc_pin_enable: assert property (p_osc_pin_enable)
    else $error("oscillator enable did not drive amplifier");

  property p_osc_runs_in_sleep;
    @(posedge clk_sys) disable iff (!reset_n)
      osc_enable_bit && sleep_mode && $past(osc_enable_bit) |->
        xtal_out_q == !$past(xtal_s2_q);
  endproperty
  a_osc_runs_in_sleep: assert property (p_osc_runs_in_sleep)
    else $error("oscillator gated during sleep");

  property p_trigger_clear;
    @(posedge clk_sys) disable iff (!reset_n)
      trig_clear && !wr_count |=> count_q == COUNT_ZERO;
  endproperty
  a_trigger_clear: assert property (p_trigger_clear)
    else $error("trigger did not clear counter");

  property p_trigger_no_flag;
    @(posedge clk_sys) disable iff (!reset_n)
      trig_clear && !peripheral_flags_q[BIT_OVERFLOW_FLAG] |=>
        !peripheral_flags_q[BIT_OVERFLOW_FLAG];
  endproperty
  a_trigger_no_flag: assert property (p_trigger_no_flag)
    else $error("trigger clear set overflow flag");

  property p_write_beats_trigger;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_low && trig_clear |=> count_q[7:0] == $past(reg_wdata);
  endproperty
  a_write_beats_trigger: assert property (p_write_beats_trigger)
    else $error("trigger overrode counter write");

  property p_soft_reset_keeps_control;
    @(posedge clk_sys) disable iff (!reset_n)
      soft_reset && !wr_tctl |=> $stable(timer_control_q);
  endproperty
  a_soft_reset_keeps_control: assert property (p_soft_reset_keeps_control)
    else $error("soft reset changed timer control");

  property p_write_clears_presc;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_count |=> presc_q == PRESC_ZERO;
  endproperty
  a_write_clears_presc: assert property (p_write_clears_presc)
    else $error("prescaler not cleared by counter write");

  property p_read_high;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_read && reg_addr == ADDR_COUNT_HIGH_BYTE |=> reg_rdata == $past(count_q[15:8]);
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("high byte read mismatch");

  property p_presc_terminal;
    @(posedge clk_sys) disable iff (!reset_n)
      presc_tick |-> presc_q == {prescale_select == 2'h3, prescale_select[1], |prescale_select};
  endproperty
  a_presc_terminal: assert property (p_presc_terminal)
    else $error("prescaler tick at wrong count");

  property p_hold_when_stopped;
    @(posedge clk_sys) disable iff (!reset_n)
      count_known && !run_enable_bit && !wr_count && !trig_clear |=> $stable(count_q);
  endproperty
  a_hold_when_stopped: assert property (p_hold_when_stopped)
    else $error("counter moved while stopped");

  property p_sync_sleep_stops;
    @(posedge clk_sys) disable iff (!reset_n)
      count_known && sleep_mode && !async_mode && !wr_count && !trig_clear |=>
        $stable(count_q);
  endproperty
  a_sync_sleep_stops: assert property (p_sync_sleep_stops)
    else $error("counter moved in sleep in sync mode");

  property p_wrap_sets_flag;
    @(posedge clk_sys) disable iff (!reset_n)
      ovf_wrap |=> count_q == COUNT_ZERO && peripheral_flags_q[BIT_OVERFLOW_FLAG] ##1
        (peripheral_flags_q[BIT_OVERFLOW_FLAG] || $past(flag_clr) || $past(soft_reset));
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag)
    else $error("wrap did not set sticky flag");

  property p_set_beats_clear;
    @(posedge clk_sys) disable iff (!reset_n)
      ovf_wrap && flag_clr && !soft_reset |=> peripheral_flags_q[BIT_OVERFLOW_FLAG];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("flag clear beat overflow set");

  property p_byte_write_only;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_high && loaded_q[0] |=>
        count_q[7:0] == $past(count_q[7:0]) && count_q[15:8] == $past(reg_wdata);
  endproperty
  a_byte_write_only: assert property (p_byte_write_only)
    else $error("byte write disturbed other byte");

endmodule

// ==== cmp_trigger_model.sv ====
// Compare unit stand-in that raises the special event trigger.
// Assumes count_value is registered on the same clock as the timer.
`timescale 1ns/1ps
module cmp_trigger_model
  import timer16_pkg::*;
(
  input  wire logic [3:0]  mode,
  input  wire logic [15:0] count_value,
  input  wire logic [15:0] compare_pair,
  input  wire logic        fire,
  output logic             trigger
);
  // Match ends the period; fire lets the bench collide it with a write
  assign trigger = (mode == MODE_SPECIAL_EVENT) &&
                   ((count_value == compare_pair) || fire);
endmodule

// ==== timer16_bench.sv ====
// Self-checking bench for timer16 with the compare unit stand-in.
// Assumes one 25 MHz clock; every input moves by NBA at a rising edge.
`timescale 1ns/1ps
module timer16_bench;
  import timer16_pkg::*;
  logic        clk_sys, irq, xout, xoe, trig;
  logic        reset_n = 1'b0, soft_reset = 1'b0, sleep_mode = 1'b0;
  logic        reg_write = 1'b0, reg_read = 1'b0, xin = 1'b0, ext_pin = 1'b0;
  logic        fire = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0]  mode = 4'h0;
  logic [15:0] cmp = 16'h0000, count_value;
  int          fails = 0, compares = 0, cycles = 0;

  timer16 dut (.clk_sys(clk_sys), .reset_n(reset_n), .soft_reset(soft_reset),
    .sleep_mode(sleep_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .crystal_input_pin(xin), .crystal_output_pin_o(xout),
    .crystal_output_pin_oe(xoe), .external_count_clock_pin(ext_pin),
    .compare_unit_mode_field(mode), .special_event_trigger(trig),
    .count_value(count_value), .irq(irq));
  cmp_trigger_model cmp_unit (.mode(mode), .count_value(count_value),
    .compare_pair(cmp), .fire(fire), .trigger(trig));

  // Clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("ERROR %0t timeout", $time);
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  // Bus write; the idle edge after it keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    chk({8'h00, d}, {8'h00, e}, w);
    @(posedge clk_sys);
  endtask
  task automatic cnt(input logic [15:0] e);
    rdc(ADDR_COUNT_LOW_BYTE, e[7:0], "count lo");
    rdc(ADDR_COUNT_HIGH_BYTE, e[15:8], "count hi");
  endtask
  task automatic setc(input logic [15:0] v);
    wr(ADDR_COUNT_LOW_BYTE, v[7:0]);
    wr(ADDR_COUNT_HIGH_BYTE, v[15:8]);
  endtask
  // Run bit is seen at exactly n edges between the two writes
  task automatic run(input logic [7:0] ctl, input int n);
    wr(ADDR_TIMER_CONTROL, ctl);
    repeat (n - 2) @(posedge clk_sys);
    wr(ADDR_TIMER_CONTROL, ctl & 8'hfe);
  endtask
  // Pin pulses slow enough for the two-flop synchroniser
  task automatic ext_run(input logic [7:0] ctl, input int n, input bit x, input logic [15:0] e);
    setc(16'h0000);
    wr(ADDR_TIMER_CONTROL, ctl);
    repeat (4) @(posedge clk_sys);
    repeat (n) begin
      xin <= x;
      ext_pin <= !x;
      repeat (3) @(posedge clk_sys);
      xin <= 1'b0;
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    wr(ADDR_TIMER_CONTROL, ctl & 8'hfe);
    cnt(e);
  endtask

  task automatic t_regs();
    rdc(ADDR_TIMER_CONTROL, 8'h00, "ctl por");
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h00, "flags por");
    rdc(ADDR_PERIPHERAL_ENABLES, 8'h00, "enables por");
    wr(8'h20, 8'h5a);
    rdc(8'h20, 8'h00, "unmapped");
    wr(ADDR_TIMER_CONTROL, 8'hfe);
    rdc(ADDR_TIMER_CONTROL, 8'h3e, "ctl mask");
    wr(ADDR_PERIPHERAL_ENABLES, 8'hff);
    rdc(ADDR_PERIPHERAL_ENABLES, 8'hcf, "enables mask");
    wr(ADDR_PERIPHERAL_ENABLES, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_bytes();
    setc(16'h1234);
    cnt(16'h1234);
    wr(ADDR_COUNT_LOW_BYTE, 8'hab);
    cnt(16'h12ab);
    wr(ADDR_COUNT_HIGH_BYTE, 8'hcd);
    cnt(16'hcdab);
    $display("test bytes done");
  endtask

  // 27 edges leave residues that only a prescaler clear removes
  task automatic t_presc();
    for (int p = 0; p < 4; p++) begin
      setc(16'h0000);
      run({2'b00, p[1:0], 4'h1}, 27);
      cnt(16'(27 >> p));
    end
    $display("test prescale done");
  endtask

  task automatic t_ovf();
    wr(ADDR_PERIPHERAL_ENABLES, 8'h01);
    wr(ADDR_INTERRUPT_CONTROL, 8'hc0);
    setc(16'hffff);
    run(8'h01, 2);
    cnt(16'h0001);
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h01, "ovf flag");
    chk({15'h0, irq}, 16'h1, "irq set");
    wr(ADDR_PERIPHERAL_ENABLES, 8'h00);
    chk({15'h0, irq}, 16'h0, "irq masked");
    wr(ADDR_PERIPHERAL_ENABLES, 8'h01);
    wr(ADDR_PERIPHERAL_FLAGS, 8'h01);
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h00, "flag clear");
    chk({15'h0, irq}, 16'h0, "irq clear");
    // Wrap and software clear in one cycle: the set must win
    setc(16'hfffe);
    wr(ADDR_TIMER_CONTROL, 8'h01);
    wr(ADDR_PERIPHERAL_FLAGS, 8'h01);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h01, "set beats clear");
    cnt(16'h0002);
    wr(ADDR_PERIPHERAL_FLAGS, 8'h01);
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h00, "flag clear again");
    $display("test overflow done");
  endtask

  task automatic t_trig();
    logic [15:0] mx;
    int          zeros;
    mx = 16'h0000;
    zeros = 0;
    cmp <= 16'h0005;
    mode <= MODE_SPECIAL_EVENT;
    setc(16'h0000);
    wr(ADDR_TIMER_CONTROL, 8'h01);
    repeat (30) begin
      @(posedge clk_sys);
      #1 if (count_value > mx) mx = count_value;
      if (count_value === 16'h0000) zeros++;
    end
    @(posedge clk_sys);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    chk(mx, 16'h0005, "period top");
    chk(16'(zeros >= 4), 16'h1, "period wraps");
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h00, "no flag");
    mode <= 4'h0;
    setc(16'h0000);
    run(8'h01, 10);
    cnt(16'h000a);
    $display("test trigger done");
  endtask

  task automatic t_race();
    cmp <= 16'h1234;
    mode <= MODE_SPECIAL_EVENT;
    setc(16'h0000);
    reg_addr <= ADDR_COUNT_LOW_BYTE;
    reg_wdata <= 8'h77;
    reg_write <= 1'b1;
    fire <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    fire <= 1'b0;
    @(posedge clk_sys);
    cnt(16'h0077);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    @(posedge clk_sys);
    cnt(16'h0000);
    rdc(ADDR_PERIPHERAL_FLAGS, 8'h00, "no flag");
    mode <= 4'h0;
    $display("test collision done");
  endtask

  task automatic t_resets();
    wr(ADDR_TIMER_CONTROL, 8'h3a);
    setc(16'hbeef);
    chk({15'h0, xoe}, 16'h1, "osc on");
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    @(posedge clk_sys);
    rdc(ADDR_TIMER_CONTROL, 8'h3a, "ctl soft");
    cnt(16'hbeef);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc(ADDR_TIMER_CONTROL, 8'h00, "ctl por");
    cnt(16'hbeef);
    chk({15'h0, xoe}, 16'h0, "osc off");
    $display("test resets done");
  endtask

  task automatic t_ext();
    ext_run(8'h03, 4, 1'b0, 16'h0004);
    ext_run(8'h0b, 3, 1'b1, 16'h0003);
    $display("test external done");
  endtask

  // Sleep stops synced counting only; the oscillator keeps going
  task automatic t_sleep();
    sleep_mode <= 1'b1;
    setc(16'h0000);
    run(8'h01, 10);
    cnt(16'h0000);
    ext_run(8'h0f, 2, 1'b1, 16'h0002);
    ext_run(8'h0b, 2, 1'b1, 16'h0000);
    repeat (4) @(posedge clk_sys);
    chk({15'h0, xout}, 16'h1, "osc in sleep");
    sleep_mode <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_bytes();
    t_presc();
    t_ovf();
    t_trig();
    t_race();
    t_ext();
    t_sleep();
    t_resets();
    end_sim();
  end
endmodule
